// file: aps_pkg.sv
// aps_pkg: constants and types shared by the amplifier protection sequencer files
// assumes a single 50 MHz clock domain and no software-visible registers
`default_nettype none

package aps_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned FAULT_PULSE_MS = 50;
  localparam int unsigned RESTART_MS = 100;
  // cycle counts derived from the time and the clock rate
  localparam int unsigned FAULT_PULSE_CYCLES = (CLOCK_HZ / 1000) * FAULT_PULSE_MS;
  localparam int unsigned RESTART_CYCLES = (CLOCK_HZ / 1000) * RESTART_MS;
  localparam int unsigned TIMER_WIDTH = 23;

  // ----------------------------------------------------------------------
  // gain foldback
  // ----------------------------------------------------------------------
  localparam int unsigned GAIN_WIDTH = 4;
  localparam logic [GAIN_WIDTH-1:0] GAIN_FULL = 4'hF;
  localparam logic [GAIN_WIDTH-1:0] GAIN_FLOOR = 4'h0;
  localparam int unsigned FOLD_STEP_CYCLES = 50_000;
  localparam int unsigned FOLD_WIDTH = 16;

  // ----------------------------------------------------------------------
  // inputs and sequencer states
  // ----------------------------------------------------------------------
  localparam int unsigned SYNC_COUNT = 10;
  localparam logic [1:0] SYNC_RESET = 2'h0;

  typedef enum logic [2:0] {
    APS_SLEEP = 3'b000,
    APS_CHARGE = 3'b001,
    APS_WINDOW = 3'b010,
    APS_MUTE = 3'b011,
    APS_OPERATE = 3'b100,
    APS_FAULT = 3'b101
  } aps_state_type;

endpackage : aps_pkg

`default_nettype wire

// file: aps_sync_if.sv
// aps_sync_if: carries raw inputs into the synchroniser and clean levels back out
// assumes both ends share the one timing clock
`default_nettype none

interface aps_sync_if;
  logic [aps_pkg::SYNC_COUNT-1:0] raw;
  logic [aps_pkg::SYNC_COUNT-1:0] clean;
  modport sync_end (input raw, output clean);
  modport user_end (output raw, input clean);
endinterface : aps_sync_if

`default_nettype wire

// file: aps_sync.sv
// aps_sync: two-flop synchronisers, one per comparator or detector input
// assumes inputs are static levels from analog comparators
`default_nettype none

module aps_sync (
  input wire logic clock,
  input wire logic reset,
  aps_sync_if.sync_end port
);

  // ----------------------------------------------------------------------
  // per-bit synchroniser chain
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < aps_pkg::SYNC_COUNT; i++) begin : g_bit
      logic [1:0] chain_q;
      // first stage is read only by the second stage
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          chain_q <= aps_pkg::SYNC_RESET;
        end else begin
          chain_q <= {chain_q[0], port.raw[i]};
        end
      end
      assign port.clean[i] = chain_q[1];
    end
  endgenerate

endmodule : aps_sync

`default_nettype wire

// file: aps_timer.sv
// aps_timer: restartable down counter for the fault pulse and restart delay
// assumes the load value fits the counter width
`default_nettype none

module aps_timer (
  input wire logic clock,
  input wire logic reset,
  input wire logic load,
  input wire logic [aps_pkg::TIMER_WIDTH-1:0] value,
  output logic running
);

  logic [aps_pkg::TIMER_WIDTH-1:0] count_q;

  // ----------------------------------------------------------------------
  // count down, load wins over counting
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      count_q <= '0;
    end else if (load) begin
      count_q <= value;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign running = (count_q != '0);

endmodule : aps_timer

`default_nettype wire

// file: aps_sequencer.sv
// aps_sequencer: protection and restart sequencer for a two-channel class-d stage
// assumes comparator inputs are levels from the analog side and the clock runs freely
`default_nettype none

// Notes on behaviour
// - mute idles bridges at half duty, audio off
// - thermal foldback steps gain down, no fault pin
// - high over-temperature disables stages and flags fault
// - overcurrent limits cycle by cycle, keeps playing
// - rail short floats stages, 50 ms pulse, 100 ms
// - rail short cycle repeats while short persists
// - window check on outputs before switching starts
// - window fail holds stages off until open
// - restart after rail short reruns window check
// - undervoltage shuts down directly and pulls the fault pin
// - undervoltage clear restarts after 100 ms
// - overvoltage disables stages, flags fault, no clamp
// - overvoltage clear restarts after 100 ms
// - unbalance trips on low or high threshold
// - symmetric unbalance releases within six percent
// - fault pin low for every protection but foldback
// - external low on fault pin forces fault
// - wake with asymmetric supply starts midrail buffers
// - asymmetric supply: no switching until capacitors fully charged
// - symmetric supply keeps midrail drivers off
module aps_sequencer #(
  parameter int unsigned FAULT_PULSE = aps_pkg::FAULT_PULSE_CYCLES,
  parameter int unsigned RESTART = aps_pkg::RESTART_CYCLES
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic wake_control,
  input wire logic engage,
  input wire logic supply_symmetric,
  input wire logic temp_foldback,
  input wire logic temp_shutdown,
  input wire logic current_limit,
  input wire logic rail_short,
  input wire logic window_short,
  input wire logic under_voltage,
  input wire logic over_voltage,
  input wire logic unbalance_trip,
  input wire logic unbalance_within,
  input wire logic caps_charged,
  input wire logic fault_indicator_in,
  output logic fault_indicator_out,
  output logic fault_indicator_oe_n,
  output logic stages_enable,
  output logic idle_switching,
  output logic input_stage_enable,
  output logic cycle_limit,
  output logic midrail_out_one,
  output logic midrail_out_two,
  output logic midrail_reference,
  output logic [aps_pkg::GAIN_WIDTH-1:0] gain,
  output logic [2:0] state
);

  // ----------------------------------------------------------------------
  // input synchronisation
  // ----------------------------------------------------------------------
  aps_sync_if sync_bus ();
  logic s_temp_fold;
  logic s_temp_shut;
  logic s_cur_limit;
  logic s_rail_short;
  logic s_win_short;
  logic s_under;
  logic s_over;
  logic s_ub_trip;
  logic s_ub_within;
  logic s_ext_fault;

  // all comparator inputs pass through two flops before use
  // wake and engage are host levels taken as they stand, without a synchroniser
  assign sync_bus.raw = {temp_foldback, temp_shutdown, current_limit, rail_short,
    window_short, under_voltage, over_voltage, unbalance_trip, unbalance_within,
    ~fault_indicator_in};
  assign {s_temp_fold, s_temp_shut, s_cur_limit, s_rail_short, s_win_short, s_under,
    s_over, s_ub_trip, s_ub_within, s_ext_fault} = sync_bus.clean;

  aps_sync u_sync (
    .clock(clock),
    .reset(reset),
    .port(sync_bus.sync_end)
  );

  // ----------------------------------------------------------------------
  // latched protections
  // ----------------------------------------------------------------------
  logic ub_active_q;
  logic rail_event;
  logic level_fault;
  logic ext_seen;
  logic pin_low_q;
  logic [1:0] own_low_q;

  // unbalance latches on a trip; symmetric supply waits for the 6 % window
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ub_active_q <= 1'b0;
    end else if (s_ub_trip) begin
      ub_active_q <= 1'b1;
    end else if (!supply_symmetric || s_ub_within) begin
      ub_active_q <= 1'b0;
    end
  end

  // a low pin while we are not driving it is the other party forcing fault; after our
  // own release the synchroniser still shows low for two edges, so that tail is masked
  // limitation: a pull-low from outside that starts while we drive the pin is not seen
  assign ext_seen = s_ext_fault && !pin_low_q && (own_low_q == 2'h0);
  assign level_fault = s_temp_shut || s_over || s_under || ub_active_q || ext_seen;
  assign rail_event = s_rail_short && stages_enable;

  // ----------------------------------------------------------------------
  // fault pulse and restart timers
  // ----------------------------------------------------------------------
  logic pulse_running;
  logic restart_running;
  logic restart_load;

  // pulse restarts on every rail short event so the cycle repeats
  // the pin is already low in the cycle of the event, so it reads one cycle past the timer
  aps_timer u_pulse (
    .clock(clock),
    .reset(reset),
    .load(rail_event),
    .value(aps_pkg::TIMER_WIDTH'(FAULT_PULSE)),
    .running(pulse_running)
  );

  // restart delay reloads while any protection still holds
  assign restart_load = rail_event || level_fault;

  aps_timer u_restart (
    .clock(clock),
    .reset(reset),
    .load(restart_load),
    .value(aps_pkg::TIMER_WIDTH'(RESTART)),
    .running(restart_running)
  );

  // ----------------------------------------------------------------------
  // mode state machine
  // ----------------------------------------------------------------------
  aps_pkg::aps_state_type state_q;
  aps_pkg::aps_state_type state_d;
  logic blocked;

  // one restart timer serves every protection: it reloads while any of them holds,
  // so the delay always runs from the last one to clear
  assign blocked = level_fault || restart_running || pulse_running;

  // sleep, charge, window check, mute, operate, with fault taking priority
  always_comb begin
    state_d = state_q;
    case (state_q)
      aps_pkg::APS_SLEEP: begin
        if (wake_control && !blocked) begin
          state_d = aps_pkg::APS_CHARGE;
        end
      end
      aps_pkg::APS_CHARGE: begin
        if (caps_charged || supply_symmetric) begin
          state_d = aps_pkg::APS_WINDOW;
        end
      end
      aps_pkg::APS_WINDOW: begin
        if (!s_win_short) begin
          state_d = aps_pkg::APS_MUTE;
        end
      end
      aps_pkg::APS_MUTE: begin
        if (engage) begin
          state_d = aps_pkg::APS_OPERATE;
        end
      end
      aps_pkg::APS_OPERATE: begin
        if (!engage) begin
          state_d = aps_pkg::APS_MUTE;
        end
      end
      aps_pkg::APS_FAULT: begin
        if (!blocked) begin
          // restart always goes back through the window check
          state_d = aps_pkg::APS_WINDOW;
        end
      end
      default: begin
        state_d = aps_pkg::APS_SLEEP;
      end
    endcase
    if (s_under) begin
      state_d = aps_pkg::APS_FAULT;
    end else if (rail_event || level_fault) begin
      state_d = aps_pkg::APS_FAULT;
    end else if (!wake_control) begin
      // dropping wake returns to sleep from any mode, fault included, unless a protection is active this cycle
      state_d = aps_pkg::APS_SLEEP;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= aps_pkg::APS_SLEEP;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // thermal foldback gain stepping
  // ----------------------------------------------------------------------
  logic [aps_pkg::FOLD_WIDTH-1:0] fold_cnt_q;
  logic [aps_pkg::GAIN_WIDTH-1:0] gain_q;
  logic fold_tick;

  // slow step so the junction settles near threshold instead of hunting
  assign fold_tick = (fold_cnt_q == aps_pkg::FOLD_WIDTH'(aps_pkg::FOLD_STEP_CYCLES - 1));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fold_cnt_q <= '0;
    end else if (fold_tick) begin
      fold_cnt_q <= '0;
    end else begin
      fold_cnt_q <= fold_cnt_q + 1'b1;
    end
  end

  // step down while hot, back up once cool; never a shutdown
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gain_q <= aps_pkg::GAIN_FULL;
    end else if (fold_tick) begin
      if (s_temp_fold && gain_q != aps_pkg::GAIN_FLOOR) begin
        gain_q <= gain_q - 1'b1;
      end else if (!s_temp_fold && gain_q != aps_pkg::GAIN_FULL) begin
        gain_q <= gain_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  logic switching_d;
  logic drive_low;

  assign switching_d = (state_d == aps_pkg::APS_MUTE) || (state_d == aps_pkg::APS_OPERATE);

  // every protection but foldback pulls the pin; the rail event counts before the pulse runs
  assign drive_low = pulse_running || rail_event || s_temp_shut || s_over || s_under
    || ub_active_q;

  // stage control: mute idles at half duty with input stages off
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stages_enable <= 1'b0;
      idle_switching <= 1'b0;
      input_stage_enable <= 1'b0;
    end else begin
      stages_enable <= switching_d;
      idle_switching <= (state_d == aps_pkg::APS_MUTE);
      input_stage_enable <= (state_d == aps_pkg::APS_OPERATE);
    end
  end

  // current limiting is passed straight to the bridges, no mode change
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cycle_limit <= 1'b0;
    end else begin
      cycle_limit <= s_cur_limit && switching_d;
    end
  end

  // midrail output buffers only in asymmetric supply and while awake
  // the reference buffer runs in both supply modes; only the two halves follow the strap
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      midrail_out_one <= 1'b0;
      midrail_out_two <= 1'b0;
      midrail_reference <= 1'b0;
    end else begin
      midrail_out_one <= wake_control && !supply_symmetric;
      midrail_out_two <= wake_control && !supply_symmetric;
      midrail_reference <= wake_control;
    end
  end

  // open drain: drive low for every protection except foldback
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pin_low_q <= 1'b0;
    end else begin
      pin_low_q <= drive_low;
    end
  end

  // history of our own drive, as deep as the synchroniser on the pin input
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      own_low_q <= aps_pkg::SYNC_RESET;
    end else begin
      own_low_q <= {own_low_q[0], pin_low_q};
    end
  end

  // the pin always drives a zero; only the enable moves
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fault_indicator_out <= 1'b0;
      fault_indicator_oe_n <= 1'b1;
    end else begin
      fault_indicator_out <= 1'b0;
      fault_indicator_oe_n <= !drive_low;
    end
  end

  // gain seen by the modulator
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      gain <= aps_pkg::GAIN_FULL;
    end else begin
      gain <= gain_q;
    end
  end

  // state shown to the host, in step with the stage controls
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= aps_pkg::APS_SLEEP;
    end else begin
      state <= state_d;
    end
  end

endmodule : aps_sequencer

`default_nettype wire

// file: aps_sequencer_properties.sv
// aps_sequencer_properties: timing relations on the sequencer's ports
// assumes comparator inputs are levels held for many cycles by the bench
`default_nettype none

module aps_sequencer_properties (
  input wire logic clock,
  input wire logic reset,
  input wire logic temp_shutdown,
  input wire logic temp_foldback,
  input wire logic under_voltage,
  input wire logic over_voltage,
  input wire logic supply_symmetric,
  input wire logic caps_charged,
  input wire logic window_short,
  input wire logic fault_indicator_in,
  input wire logic fault_indicator_out,
  input wire logic fault_indicator_oe_n,
  input wire logic stages_enable,
  input wire logic idle_switching,
  input wire logic input_stage_enable,
  input wire logic midrail_out_one,
  input wire logic midrail_out_two,
  input wire logic [2:0] state
);
  timeunit 1ns;
  timeprecision 1ps;
  // -------------------------------------------------------------
  // port relations; the 2-flop sync allows up to 4 edges of delay
  // -------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  out_zero_a: assert property (fault_indicator_out == 1'b0)
    else $error("fault pin data not low");
  otp_off_a: assert property ($rose(temp_shutdown) |-> ##[1:4]
    (!stages_enable && !fault_indicator_oe_n)) else $error("over-temperature not acted on");
  ovp_off_a: assert property ($rose(over_voltage) |-> ##[1:4]
    (!stages_enable && !fault_indicator_oe_n)) else $error("overvoltage not acted on");
  uvp_off_a: assert property ($rose(under_voltage) |-> ##[1:4] !stages_enable)
    else $error("undervoltage left stages on");
  uvp_hold_a: assert property ($fell(under_voltage) |-> !stages_enable [*8])
    else $error("restart came too early");
  mute_idle_a: assert property (state == aps_pkg::APS_MUTE |->
    (stages_enable && idle_switching && !input_stage_enable)) else $error("mute outputs wrong");
  start_gate_a: assert property ($rose(stages_enable) |->
    ((supply_symmetric || caps_charged) && !window_short)) else $error("switching started early");
  sym_mid_a: assert property (supply_symmetric |->
    (!midrail_out_one && !midrail_out_two)) else $error("midrail drivers on");
  ext_fault_a: assert property ($fell(fault_indicator_in) && fault_indicator_oe_n |->
    ##[1:4] state == aps_pkg::APS_FAULT) else $error("external pull-low ignored");
  fold_pin_a: assert property ($rose(temp_foldback) |-> fault_indicator_oe_n [*6])
    else $error("foldback drove fault pin");
endmodule // aps_sequencer_properties

bind aps_sequencer aps_sequencer_properties chk (.clock(clock), .reset(reset),
  .temp_shutdown(temp_shutdown), .temp_foldback(temp_foldback),
  .under_voltage(under_voltage), .over_voltage(over_voltage),
  .supply_symmetric(supply_symmetric), .caps_charged(caps_charged),
  .window_short(window_short), .fault_indicator_in(fault_indicator_in),
  .fault_indicator_out(fault_indicator_out), .fault_indicator_oe_n(fault_indicator_oe_n),
  .stages_enable(stages_enable), .idle_switching(idle_switching),
  .input_stage_enable(input_stage_enable), .midrail_out_one(midrail_out_one),
  .midrail_out_two(midrail_out_two), .state(state));

`default_nettype wire

// file: aps_stage_model.sv
// aps_stage_model: power stages, coupling capacitors and the pulled-up fault pin
// assumes the bench decides when an output short or an external pull-low exists
`default_nettype none

module aps_stage_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic stages_enable,
  input wire logic midrail_reference,
  input wire logic fault_indicator_oe_n,
  input wire logic short_present,
  input wire logic ext_low,
  output logic caps_charged,
  output logic rail_short,
  output logic window_short,
  output logic fault_indicator_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] charge_q;
  // capacitors charge slowly so the gate on switching is really exercised
  always_ff @(posedge clock or posedge reset) begin
    if (reset || !midrail_reference) charge_q <= 5'h00;
    else if (charge_q != 5'h1F) charge_q <= charge_q + 5'h01;
  end
  assign caps_charged = (charge_q == 5'h1F);
  // short current only flows while the stages switch
  assign rail_short = short_present & stages_enable;
  assign window_short = short_present;
  // pull-up wins unless either party pulls low
  assign fault_indicator_in = fault_indicator_oe_n & ~ext_low;
endmodule // aps_stage_model

`default_nettype wire

// file: aps_sequencer_tb_top.sv
// aps_sequencer_tb_top: self-checking bench for the protection sequencer
// assumes shortened timers: fault pulse 50 cycles, restart 100 cycles
`default_nettype none

module aps_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset = 1'b1, wake = 1'b0, engage = 1'b0, sym = 1'b0;
  logic fold = 1'b0, otp = 1'b0, ilim = 1'b0, undervoltage_lockout = 1'b0, overvoltage_shutdown = 1'b0;
  logic ubt = 1'b0, ubw = 1'b0, short_p = 1'b0, ext_low = 1'b0;
  logic caps, rshort, wshort, pin_in, pin_out, oe_n, stg, idle, inen, climit;
  logic mid1, mid2, midref;
  logic [3:0] gain;
  logic [2:0] state;
  int errors = 0, checks_done = 0;
  always #10 clock = ~clock;
  aps_sequencer #(.FAULT_PULSE(50), .RESTART(100)) DUT (.clock(clock), .reset(reset),
    .wake_control(wake), .engage(engage), .supply_symmetric(sym), .temp_foldback(fold),
    .temp_shutdown(otp), .current_limit(ilim), .rail_short(rshort),
    .window_short(wshort), .under_voltage(undervoltage_lockout), .over_voltage(overvoltage_shutdown),
    .unbalance_trip(ubt), .unbalance_within(ubw), .caps_charged(caps),
    .fault_indicator_in(pin_in), .fault_indicator_out(pin_out),
    .fault_indicator_oe_n(oe_n), .stages_enable(stg), .idle_switching(idle),
    .input_stage_enable(inen), .cycle_limit(climit), .midrail_out_one(mid1),
    .midrail_out_two(mid2), .midrail_reference(midref), .gain(gain), .state(state));
  aps_stage_model far (.clock(clock), .reset(reset), .stages_enable(stg),
    .midrail_reference(midref), .fault_indicator_oe_n(oe_n), .short_present(short_p),
    .ext_low(ext_low), .caps_charged(caps), .rail_short(rshort), .window_short(wshort),
    .fault_indicator_in(pin_in));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  // bounded wait on the sequencer state; a hang ends the run
  task automatic wait_state(input logic [2:0] s, input int bound);
    for (int i = 0; i < bound; i++) begin
      @(negedge clock);
      if (state === s) return;
    end
    errors++;
    $display("MISMATCH state_wait expected %0h seen %0h", s, state);
    stop_test();
  endtask
  task automatic do_reset(input logic symmetric);
    reset = 1'b1; wake = 1'b0; engage = 1'b0; sym = symmetric;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    check("oe_n_reset", oe_n, 1);
    wake = 1'b1;
    wait_state(aps_pkg::APS_MUTE, 200);
    check("midrail", {mid1, mid2, midref}, {!symmetric, !symmetric, 1'b1});
    check("mute_idle", idle, 1);
    engage = 1'b1;
    wait_state(aps_pkg::APS_OPERATE, 20);
    check("audio_on", {inen, idle}, 2'h2);
    $display("test startup done");
  endtask
  // one level protection: 0 temp, 1 over, 2 under, 3 unbalance
  task automatic level_fault(input int k);
    int n;
    {ubt, undervoltage_lockout, overvoltage_shutdown, otp} = 4'h1 << k;
    wait_state(aps_pkg::APS_FAULT, 20);
    check("stages_off", stg, 0);
    check("pin_low", oe_n, 0);
    {ubt, undervoltage_lockout, overvoltage_shutdown, otp} = 4'h0;
    n = 0;
    while (state === aps_pkg::APS_FAULT && n < 400) begin
      @(negedge clock);
      n++;
    end
    check("restart_wait", n >= 100 && n <= 110, 1);
    wait_state(aps_pkg::APS_OPERATE, 400);
    $display("test level fault %0d done", k);
  endtask
  task automatic rail_short_case();
    int n;
    short_p = 1'b1;
    wait_state(aps_pkg::APS_FAULT, 20);
    check("float", stg, 0);
    n = 0;
    while (oe_n === 1'b0 && n < 200) begin
      @(negedge clock);
      n++;
    end
    check("pulse_len", n >= 49 && n <= 51, 1);
    wait_state(aps_pkg::APS_WINDOW, 200);
    repeat (20) @(negedge clock);
    check("held_window", {state, stg}, {aps_pkg::APS_WINDOW, 1'b0});
    short_p = 1'b0;
    wait_state(aps_pkg::APS_OPERATE, 50);
    $display("test rail short done");
  endtask
  task automatic overlap_ext_case();
    overvoltage_shutdown = 1'b1; undervoltage_lockout = 1'b1;
    wait_state(aps_pkg::APS_FAULT, 20);
    overvoltage_shutdown = 1'b0;
    repeat (150) @(negedge clock);
    check("still_off", stg, 0);
    undervoltage_lockout = 1'b0;
    wait_state(aps_pkg::APS_OPERATE, 400);
    ext_low = 1'b1;
    wait_state(aps_pkg::APS_FAULT, 20);
    check("ext_fault", stg, 0);
    ext_low = 1'b0;
    wait_state(aps_pkg::APS_OPERATE, 400);
    $display("test overlap and external done");
  endtask
  task automatic fold_limit_case();
    int n;
    ilim = 1'b1;
    repeat (6) @(negedge clock);
    check("limit", {climit, state}, {1'b1, aps_pkg::APS_OPERATE});
    ilim = 1'b0; fold = 1'b1; n = 0;
    while (gain === 4'hF && n < 52000) begin
      @(negedge clock);
      n++;
    end
    check("gain_step", {gain, oe_n, state}, {4'hE, 1'b1, aps_pkg::APS_OPERATE});
    fold = 1'b0;
    $display("test foldback done");
  endtask
  task automatic sym_unbalance_case();
    do_reset(1'b1);
    ubt = 1'b1;
    wait_state(aps_pkg::APS_FAULT, 20);
    ubt = 1'b0;
    repeat (200) @(negedge clock);
    check("wait_within", state, aps_pkg::APS_FAULT);
    ubw = 1'b1;
    wait_state(aps_pkg::APS_OPERATE, 400);
    $display("test symmetric unbalance done");
  endtask

  // main sequence
  initial begin
    @(negedge clock);
    do_reset(1'b0);
    for (int k = 0; k < 4; k++) level_fault(k);
    rail_short_case();
    overlap_ext_case();
    fold_limit_case();
    sym_unbalance_case();
    stop_test();
  end
endmodule // aps_sequencer_tb_top

`default_nettype wire
